// ===== rtl/sdc_consts.vh
// Register offsets, field positions and reset values of the display controller
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// Register byte offsets
`define SDC_OFF_CTRL0 8'h00
`define SDC_OFF_CTRL1 8'h04
`define SDC_OFF_RVC 8'h08
`define SDC_OFF_POWER 8'h0C
`define SDC_OFF_BLINK 8'h10
`define SDC_OFF_STATUS 8'h14
`define SDC_OFF_PEN_LO 8'h18
`define SDC_OFF_PEN_HI 8'h1C
`define SDC_OFF_BACKPLANE_ROLE_ENABLE_LO 8'h20
`define SDC_OFF_BACKPLANE_ROLE_ENABLE_HI 8'h24
// Control 0 fields
`define SDC_C0_DUTY_LSB 0
`define SDC_C0_CLKDIV_LSB 3
`define SDC_C0_SOURCE 6
`define SDC_C0_ON 7
// Control 1 fields
`define SDC_C1_IEN 7
`define SDC_C1_STOPOFF 1
`define SDC_C1_WAITOFF 0
// Regulated voltage control fields
`define SDC_RV_ON 7
`define SDC_RV_TRIM_LSB 0
// Power control fields
`define SDC_PW_CHARGE_PUMP_SELECT 7
`define SDC_PW_HREF 6
`define SDC_PW_PUMP_CLOCK_TUNE_LSB 4
`define SDC_PW_BSKIP 3
`define SDC_PW_VSUP_LSB 0
`define SDC_VSUP_EXTERNAL 2'h2
// Blink control fields
`define SDC_BL_BLINK 7
`define SDC_BL_ALT 6
`define SDC_BL_BLANK 5
`define SDC_BL_STYLE 3
`define SDC_BL_RATE_LSB 0
// Status fields
`define SDC_ST_FLAG 7
// Reset values: 1/4 duty, power register at supply code 11
`define SDC_RST_CTRL0 8'h03
`define SDC_RST_CTRL1 8'h00
`define SDC_RST_RVC 8'h00
`define SDC_RST_POWER 8'h03
`define SDC_RST_BLINK 8'h00
// Frame event divider length in selected display clock ticks at divider field 7
`define SDC_FRAME_BASE 16'h0100
`endif

// ===== rtl/sdc_segment_display_ctrl.v
// AXI4-Lite configuration and enable sequencing for a segment display driver
`default_nettype none
`include "sdc_consts.vh"

// How it works
// - No display drive until module enable set
// - Reference select: doubler 0, tripler 1
// - Reference select picks 1.0 or 1.67 V
// - Regulated voltage enable and trim field
// - Charge pump select enables pump
// - Buffer skip: buffered 0, unbuffered 1
// - Supply code 10 means external power
// - Wait control 0 keeps display in wait
// - Stop control 0 keeps display in stop
// - Interrupt enable 0 blocks frame request
// - 64 pin enables make display outputs
// - 64 backplane enables select backplane role
// - 3-bit duty and frame divider fields
// - Alternate, blank, blink style, blink rate
// - Clock source bit selects timing clock
// - Frame event sets flag, write-one clears
// - Interrupt when flag and enable set
// - Reset clears enable, outputs high impedance
// - Trim steps 1.5 percent, 12 percent range
module sdc_segment_display_ctrl #(
	parameter PINS = 64
) (
	input wire clk_sys,
	input wire reset,
	input wire extClkTick,
	input wire intClkTick,
	input wire sysWaitMode,
	input wire sysStopMode,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [PINS-1:0] pinDriveEnable,
	output reg [PINS-1:0] backplaneRole,
	output reg displayActive,
	output reg frameEventPulse,
	output reg frameIrq,
	output reg [2:0] dutySelect,
	output reg [2:0] blinkPeriodSelect,
	output reg secondPlaneSelect,
	output reg blankActive,
	output reg blinkStyle,
	output reg blinkEnable,
	output reg biasRefHighSelect,
	output reg regVoltageOn,
	output reg [3:0] regVoltageAdjust,
	output reg chargePumpSelect,
	output reg [1:0] pumpClockTune,
	output reg bufferSkip,
	output reg [1:0] supplySourceSelect,
	output reg externalSupply
);

	// Register storage
	reg [7:0] displayCtrl0_reg;
	reg [7:0] displayCtrl1_reg;
	reg [7:0] regVoltageCtrl_reg;
	reg [7:0] displayPowerCtrl_reg;
	reg [7:0] blinkCtrl_reg;
	reg frameEventFlag_reg;
	reg [PINS-1:0] pinEnable_reg;
	reg [PINS-1:0] backplaneEnable_reg;
	reg [31:0] awAddr_reg;
	reg awHeld_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	reg wHeld_reg;
	reg extSync1_reg;
	reg extSync2_reg;
	reg extPrev_reg;
	reg intSync1_reg;
	reg intSync2_reg;
	reg intPrev_reg;
	reg waitSync1_reg;
	reg waitSync2_reg;
	reg stopSync1_reg;
	reg stopSync2_reg;
	reg [15:0] frameCnt_reg;
	reg [15:0] frameCnt_next;

	wire [7:0] writeByte;
	wire [7:0] writeAddr;
	wire [7:0] readAddr;
	wire doWrite;
	wire doRead;
	wire moduleOn;
	wire lowPowerOff;
	wire driveNow;
	wire clkTick;
	wire [15:0] frameLength;

	// Byte-lane merge of one 8-bit register
	function [7:0] mergeByte;
		input [7:0] oldVal;
		input [31:0] data;
		input [3:0] strb;
		begin
			mergeByte = strb[0] ? data[7:0] : oldVal;
		end
	endfunction

	// Merge a 32-bit word with byte strobes
	function [31:0] mergeWord;
		input [31:0] oldVal;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			mergeWord = oldVal;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					mergeWord[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// Address and data may arrive in either order
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign writeAddr = awAddr_reg[7:0];
	assign readAddr = s_axi_araddr[7:0];
	assign writeByte = mergeByte(8'h00, wData_reg, wStrb_reg);

	assign moduleOn = displayCtrl0_reg[`SDC_C0_ON];
	// Low-power gating of the drive
	assign lowPowerOff =
		(waitSync2_reg && displayCtrl1_reg[`SDC_C1_WAITOFF]) ||
		(stopSync2_reg && displayCtrl1_reg[`SDC_C1_STOPOFF]);
	assign driveNow = moduleOn && !lowPowerOff;
	// Clock source choice between the two timing ticks
	assign clkTick = displayCtrl0_reg[`SDC_C0_SOURCE] ?
		(intSync2_reg && !intPrev_reg) :
		(extSync2_reg && !extPrev_reg);
	// Frame length scales with the divider field
	assign frameLength = `SDC_FRAME_BASE >>
		(3'h7 - displayCtrl0_reg[`SDC_C0_CLKDIV_LSB +: 3]);

	// Synchronisers for outside ticks and mode levels
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			extSync1_reg <= 1'b0;
			extSync2_reg <= 1'b0;
			extPrev_reg <= 1'b0;
			intSync1_reg <= 1'b0;
			intSync2_reg <= 1'b0;
			intPrev_reg <= 1'b0;
			waitSync1_reg <= 1'b0;
			waitSync2_reg <= 1'b0;
			stopSync1_reg <= 1'b0;
			stopSync2_reg <= 1'b0;
		end else begin
			extSync1_reg <= extClkTick;
			extSync2_reg <= extSync1_reg;
			extPrev_reg <= extSync2_reg;
			intSync1_reg <= intClkTick;
			intSync2_reg <= intSync1_reg;
			intPrev_reg <= intSync2_reg;
			waitSync1_reg <= sysWaitMode;
			waitSync2_reg <= waitSync1_reg;
			stopSync1_reg <= sysStopMode;
			stopSync2_reg <= stopSync1_reg;
		end
	end

	// Frame counter next value, runs only while driving
	always @* begin
		frameCnt_next = frameCnt_reg;
		if (!driveNow)
			frameCnt_next = 16'h0000;
		else if (clkTick) begin
			if (frameCnt_reg >= frameLength - 16'h0001)
				frameCnt_next = 16'h0000;
			else
				frameCnt_next = frameCnt_reg + 16'h0001;
		end
	end

	// Bus channels and register writes
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			awAddr_reg <= 32'h0000_0000;
			awHeld_reg <= 1'b0;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			wHeld_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
			displayCtrl0_reg <= `SDC_RST_CTRL0;
			displayCtrl1_reg <= `SDC_RST_CTRL1;
			regVoltageCtrl_reg <= `SDC_RST_RVC;
			displayPowerCtrl_reg <= `SDC_RST_POWER;
			blinkCtrl_reg <= `SDC_RST_BLINK;
			frameEventFlag_reg <= 1'b0;
			pinEnable_reg <= {PINS{1'b0}};
			backplaneEnable_reg <= {PINS{1'b0}};
			frameCnt_reg <= 16'h0000;
		end else begin
			frameCnt_reg <= frameCnt_next;
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_reg <= s_axi_awaddr;
				awHeld_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
				wHeld_reg <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (writeAddr)
				`SDC_OFF_CTRL0: begin
					if (wStrb_reg[0])
						displayCtrl0_reg <= writeByte;
				end
				`SDC_OFF_CTRL1: begin
					if (wStrb_reg[0])
						displayCtrl1_reg <= writeByte;
				end
				`SDC_OFF_RVC: begin
					if (wStrb_reg[0])
						regVoltageCtrl_reg <= writeByte;
				end
				`SDC_OFF_POWER: begin
					if (wStrb_reg[0])
						displayPowerCtrl_reg <= writeByte;
				end
				`SDC_OFF_BLINK: begin
					if (wStrb_reg[0])
						blinkCtrl_reg <= writeByte;
				end
				`SDC_OFF_STATUS: ;
				`SDC_OFF_PEN_LO: pinEnable_reg[31:0] <= mergeWord(
					pinEnable_reg[31:0], wData_reg, wStrb_reg);
				`SDC_OFF_PEN_HI: pinEnable_reg[63:32] <= mergeWord(
					pinEnable_reg[63:32], wData_reg, wStrb_reg);
				`SDC_OFF_BACKPLANE_ROLE_ENABLE_LO: backplaneEnable_reg[31:0] <= mergeWord(
					backplaneEnable_reg[31:0], wData_reg, wStrb_reg);
				`SDC_OFF_BACKPLANE_ROLE_ENABLE_HI: backplaneEnable_reg[63:32] <= mergeWord(
					backplaneEnable_reg[63:32], wData_reg, wStrb_reg);
				default: s_axi_bresp <= 2'h2;
				endcase
			end
			// Frame flag: a new event wins over a clear
			if (driveNow && clkTick && frameCnt_next == 16'h0000)
				frameEventFlag_reg <= 1'b1;
			else if (doWrite && writeAddr == `SDC_OFF_STATUS &&
				wStrb_reg[0] && wData_reg[`SDC_ST_FLAG])
				frameEventFlag_reg <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (readAddr)
				`SDC_OFF_CTRL0: s_axi_rdata <= {24'h00_0000, displayCtrl0_reg};
				`SDC_OFF_CTRL1: s_axi_rdata <= {24'h00_0000, displayCtrl1_reg};
				`SDC_OFF_RVC: s_axi_rdata <= {24'h00_0000, regVoltageCtrl_reg};
				`SDC_OFF_POWER:
					s_axi_rdata <= {24'h00_0000, displayPowerCtrl_reg};
				`SDC_OFF_BLINK: s_axi_rdata <= {24'h00_0000, blinkCtrl_reg};
				`SDC_OFF_STATUS: s_axi_rdata <= {24'h00_0000,
					frameEventFlag_reg, 7'h00};
				`SDC_OFF_PEN_LO: s_axi_rdata <= pinEnable_reg[31:0];
				`SDC_OFF_PEN_HI: s_axi_rdata <= pinEnable_reg[63:32];
				`SDC_OFF_BACKPLANE_ROLE_ENABLE_LO: s_axi_rdata <= backplaneEnable_reg[31:0];
				`SDC_OFF_BACKPLANE_ROLE_ENABLE_HI: s_axi_rdata <= backplaneEnable_reg[63:32];
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end
		end
	end

	// Registered outputs toward the driver and analog blocks
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pinDriveEnable <= {PINS{1'b0}};
			backplaneRole <= {PINS{1'b0}};
			displayActive <= 1'b0;
			frameEventPulse <= 1'b0;
			frameIrq <= 1'b0;
			dutySelect <= 3'h3;
			blinkPeriodSelect <= 3'h0;
			secondPlaneSelect <= 1'b0;
			blankActive <= 1'b0;
			blinkStyle <= 1'b0;
			blinkEnable <= 1'b0;
			biasRefHighSelect <= 1'b0;
			regVoltageOn <= 1'b0;
			regVoltageAdjust <= 4'h0;
			chargePumpSelect <= 1'b0;
			pumpClockTune <= 2'h0;
			bufferSkip <= 1'b0;
			supplySourceSelect <= 2'h3;
			externalSupply <= 1'b0;
		end else begin
			// Pins float unless the module drives
			pinDriveEnable <= driveNow ? pinEnable_reg : {PINS{1'b0}};
			backplaneRole <= pinEnable_reg & backplaneEnable_reg;
			displayActive <= driveNow;
			frameEventPulse <= driveNow && clkTick && frameCnt_next == 16'h0000;
			frameIrq <= frameEventFlag_reg &&
				displayCtrl1_reg[`SDC_C1_IEN];
			dutySelect <= displayCtrl0_reg[`SDC_C0_DUTY_LSB +: 3];
			blinkPeriodSelect <= blinkCtrl_reg[`SDC_BL_RATE_LSB +: 3];
			secondPlaneSelect <= blinkCtrl_reg[`SDC_BL_ALT];
			blankActive <= blinkCtrl_reg[`SDC_BL_BLANK];
			blinkStyle <= blinkCtrl_reg[`SDC_BL_STYLE];
			blinkEnable <= blinkCtrl_reg[`SDC_BL_BLINK];
			biasRefHighSelect <= displayPowerCtrl_reg[`SDC_PW_HREF];
			regVoltageOn <= regVoltageCtrl_reg[`SDC_RV_ON];
			regVoltageAdjust <= regVoltageCtrl_reg[`SDC_RV_TRIM_LSB +: 4];
			chargePumpSelect <= displayPowerCtrl_reg[`SDC_PW_CHARGE_PUMP_SELECT];
			pumpClockTune <= displayPowerCtrl_reg[`SDC_PW_PUMP_CLOCK_TUNE_LSB +: 2];
			bufferSkip <= displayPowerCtrl_reg[`SDC_PW_BSKIP];
			supplySourceSelect <= displayPowerCtrl_reg[`SDC_PW_VSUP_LSB +: 2];
			externalSupply <= displayPowerCtrl_reg[`SDC_PW_VSUP_LSB +: 2] ==
				`SDC_VSUP_EXTERNAL;
		end
	end

endmodule // sdc_segment_display_ctrl
`default_nettype wire

// ===== test/sdc_props.sv
// Port checker for the segment display controller
`default_nettype none
module sdc_props #(
	parameter PINS = 64
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [PINS-1:0] pinDriveEnable,
	input wire logic [PINS-1:0] backplaneRole,
	input wire logic displayActive,
	input wire logic frameEventPulse,
	input wire logic frameIrq,
	input wire logic [2:0] dutySelect,
	input wire logic [1:0] supplySourceSelect,
	input wire logic externalSupply
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Defaults seen on the first edge after reset leaves
	a_reset_defaults: assert property ($past(reset) |->
		dutySelect == 3'h3 && !displayActive && pinDriveEnable == '0)
		else $error("defaults wrong after reset");
	a_off_quiet: assert property (!displayActive |->
		pinDriveEnable == '0) else $error("pins driven while off");
	a_bp_enabled: assert property (displayActive |->
		(backplaneRole & ~pinDriveEnable) == '0)
		else $error("backplane on a disabled pin");
	a_no_event_off: assert property (!displayActive &&
		!$past(displayActive) |-> !frameEventPulse)
		else $error("frame event while off");
	a_pulse_single: assert property (frameEventPulse |=>
		!frameEventPulse) else $error("frame pulse too long");
	a_ext_supply: assert property (
		externalSupply == (supplySourceSelect == 2'h2))
		else $error("external supply mismatch");
	a_write_block: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	// Main scenarios reached
	c_event: cover property (frameEventPulse);
	c_irq: cover property (frameIrq);
	c_on: cover property ($rose(displayActive));
endmodule // sdc_props
bind sdc_segment_display_ctrl sdc_props #(.PINS(PINS)) i_props (
	.clk_sys(clk_sys), .reset(reset), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.pinDriveEnable(pinDriveEnable), .backplaneRole(backplaneRole),
	.displayActive(displayActive), .frameEventPulse(frameEventPulse),
	.frameIrq(frameIrq), .dutySelect(dutySelect),
	.supplySourceSelect(supplySourceSelect),
	.externalSupply(externalSupply));
`default_nettype wire

// ===== test/sdc_glass_model.sv
// Passive segment glass seen from the driver pins
`default_nettype none
module sdc_glass_model #(
	parameter PINS = 64
) (
	input wire logic [PINS-1:0] pinDriveEnable,
	input wire logic [PINS-1:0] backplaneRole,
	output var logic [PINS-1:0] frontPlanes,
	output var logic anyDriven
);
	timeunit 1ns;
	timeprecision 1ps;
	// A pin loads the glass only while driven
	always_comb begin
		frontPlanes = pinDriveEnable & ~backplaneRole;
		anyDriven = |pinDriveEnable;
	end
endmodule // sdc_glass_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the segment display controller
`default_nettype none
`include "sdc_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] PE = 64'h8000_0001_00FF_FFFF;
	localparam logic [63:0] BE = 64'h8000_0001_0000_00FF;
	logic clk_sys, reset, extClkTick, intClkTick, sysWaitMode, sysStopMode;
	logic awv, wv, bre, arv, rre, sawEvent;
	logic [31:0] awa, wd, ara;
	logic [3:0] ws;
	logic [1:0] lastBresp;
	wire awr, wr_, bv, arr, rv, displayActive, frameEventPulse, frameIrq;
	wire secondPlaneSelect, blankActive, blinkStyle, blinkEnable, anyDriven;
	wire biasRefHighSelect, regVoltageOn, chargePumpSelect, bufferSkip;
	wire externalSupply;
	wire [1:0] bresp, rresp, pumpClockTune, supplySourceSelect;
	wire [31:0] rdata;
	wire [63:0] pinDriveEnable, backplaneRole, frontPlanes;
	wire [2:0] dutySelect, blinkPeriodSelect;
	wire [3:0] regVoltageAdjust;
	int miscompares = 0;
	int comparisons = 0;
	sdc_segment_display_ctrl #(.PINS(64)) i_dut (.clk_sys(clk_sys),
		.reset(reset), .extClkTick(extClkTick), .intClkTick(intClkTick),
		.sysWaitMode(sysWaitMode), .sysStopMode(sysStopMode),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rre),
		.pinDriveEnable(pinDriveEnable), .backplaneRole(backplaneRole),
		.displayActive(displayActive), .frameEventPulse(frameEventPulse),
		.frameIrq(frameIrq), .dutySelect(dutySelect),
		.blinkPeriodSelect(blinkPeriodSelect),
		.secondPlaneSelect(secondPlaneSelect), .blankActive(blankActive),
		.blinkStyle(blinkStyle), .blinkEnable(blinkEnable),
		.biasRefHighSelect(biasRefHighSelect), .regVoltageOn(regVoltageOn),
		.regVoltageAdjust(regVoltageAdjust),
		.chargePumpSelect(chargePumpSelect), .pumpClockTune(pumpClockTune),
		.bufferSkip(bufferSkip), .supplySourceSelect(supplySourceSelect),
		.externalSupply(externalSupply));
	sdc_glass_model #(.PINS(64)) i_glass (.pinDriveEnable(pinDriveEnable),
		.backplaneRole(backplaneRole), .frontPlanes(frontPlanes),
		.anyDriven(anyDriven));
	// System clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Remembers any frame event since last cleared
	always @(posedge clk_sys) begin
		if (frameEventPulse === 1'b1) sawEvent <= 1'b1;
	end
	task automatic summarize;
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Write: both channels offered, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awa <= {24'h00_0000, a};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awr) awv <= 1'b0;
			if (wr_) wv <= 1'b0;
		end while (bv !== 1'b1);
		lastBresp = bresp;
		bre <= 1'b0;
		cyc(2);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		ara <= {24'h00_0000, a};
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdata;
		r = rresp;
		rre <= 1'b0;
		cyc(1);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("register", d, e);
	endtask
	// Ticks of a display clock, each high three cycles
	task automatic tick(input logic ext, input int n);
		repeat (n) begin
			if (ext) extClkTick <= 1'b1;
			else intClkTick <= 1'b1;
			cyc(3);
			extClkTick <= 1'b0;
			intClkTick <= 1'b0;
			cyc(3);
		end
		cyc(4);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rc(`SDC_OFF_CTRL0, 32'h0000_0003);
		rc(`SDC_OFF_POWER, 32'h0000_0003);
		rc(`SDC_OFF_CTRL1, 32'h0000_0000);
		chk("duty", dutySelect, 3'h3);
		chk("pins", pinDriveEnable, 64'h0);
		rd(8'h40, d, r);
		chk("rresp", r, 2'h2);
		chk("rdata", d, 32'h0000_0000);
		wr(8'h40, 32'h0000_0000);
		chk("bresp", lastBresp, 2'h2);
	endtask
	task automatic t_config;
		logic [31:0] d;
		logic [7:0] p;
		wr(`SDC_OFF_CTRL0, 32'h0000_0040);
		wr(`SDC_OFF_RVC, 32'h0000_008A);
		chk("bresp ok", lastBresp, 2'h0);
		chk("regv", {regVoltageOn, regVoltageAdjust}, 5'h1A);
		for (int i = 0; i < 4; i++) begin
			d = {24'h00_0000, i[0], i[1], i[1:0], i[0], 1'b0, i[1:0]};
			wr(`SDC_OFF_POWER, d);
			p = {chargePumpSelect, biasRefHighSelect, pumpClockTune,
				bufferSkip, supplySourceSelect, externalSupply};
			chk("power", p, {d[7:3], d[1:0], d[1:0] == 2'h2});
		end
		wr(`SDC_OFF_CTRL1, 32'h0000_0000);
		wr(`SDC_OFF_CTRL0, 32'h0000_006F);
		chk("duty", dutySelect, 3'h7);
		wr(`SDC_OFF_BLINK, 32'h0000_00EB);
		p = {1'b0, blinkEnable, secondPlaneSelect, blankActive, blinkStyle,
			blinkPeriodSelect};
		chk("blink", p, 8'h7B);
		wr(`SDC_OFF_PEN_LO, 32'h00FF_FFFF);
		wr(`SDC_OFF_PEN_HI, 32'h8000_0001);
		wr(`SDC_OFF_BACKPLANE_ROLE_ENABLE_LO, 32'h0000_00FF);
		wr(`SDC_OFF_BACKPLANE_ROLE_ENABLE_HI, 32'hFFFF_FFFF);
		sawEvent <= 1'b0;
		tick(1'b0, 4);
		chk("idle glass", anyDriven, 1'b0);
		chk("idle event", sawEvent, 1'b0);
		wr(`SDC_OFF_CTRL0, 32'h0000_00C3);
		chk("active", displayActive, 1'b1);
		chk("pins", pinDriveEnable, PE);
		chk("backplanes", backplaneRole, BE);
		chk("fronts", frontPlanes, PE & ~BE);
		// Byte strobes: only the lanes offered are written
		ws <= 4'h1;
		wr(`SDC_OFF_PEN_LO, 32'h0000_0000);
		ws <= 4'h2;
		wr(`SDC_OFF_CTRL1, 32'h0000_0080);
		ws <= 4'hF;
		chk("lane pins", pinDriveEnable, PE & ~64'hFF);
		rc(`SDC_OFF_CTRL1, 32'h0000_0000);
	endtask
	task automatic t_frame;
		sawEvent <= 1'b0;
		tick(1'b0, 1);
		chk("one tick", sawEvent, 1'b0);
		tick(1'b0, 1);
		chk("two ticks", sawEvent, 1'b1);
		rc(`SDC_OFF_STATUS, 32'h0000_0080);
		chk("irq off", frameIrq, 1'b0);
		wr(`SDC_OFF_STATUS, 32'h0000_0080);
		rc(`SDC_OFF_STATUS, 32'h0000_0000);
		wr(`SDC_OFF_CTRL1, 32'h0000_0080);
		chk("irq idle", frameIrq, 1'b0);
		tick(1'b0, 2);
		chk("irq", frameIrq, 1'b1);
		wr(`SDC_OFF_CTRL1, 32'h0000_0000);
		chk("irq masked", frameIrq, 1'b0);
		wr(`SDC_OFF_CTRL0, 32'h0000_0083);
		sawEvent <= 1'b0;
		tick(1'b0, 2);
		chk("int ignored", sawEvent, 1'b0);
		tick(1'b1, 2);
		chk("ext ticks", sawEvent, 1'b1);
		// Divider one doubles the frame to four ticks
		wr(`SDC_OFF_CTRL0, 32'h0000_008B);
		sawEvent <= 1'b0;
		tick(1'b1, 3);
		chk("div one short", sawEvent, 1'b0);
		tick(1'b1, 1);
		chk("div one frame", sawEvent, 1'b1);
	endtask
	task automatic t_low;
		sysWaitMode <= 1'b1;
		cyc(6);
		chk("wait on", displayActive, 1'b1);
		wr(`SDC_OFF_CTRL1, 32'h0000_0001);
		cyc(4);
		chk("wait off", displayActive, 1'b0);
		chk("wait pins", pinDriveEnable, 64'h0);
		sysWaitMode <= 1'b0;
		sysStopMode <= 1'b1;
		cyc(6);
		chk("stop on", displayActive, 1'b1);
		wr(`SDC_OFF_CTRL1, 32'h0000_0002);
		cyc(4);
		chk("stop off", displayActive, 1'b0);
		sysStopMode <= 1'b0;
	endtask
	// Cuts a hang short
	initial begin
		cyc(20000);
		miscompares++;
		summarize();
	end
	// Main sequence
	initial begin
		{reset, extClkTick, intClkTick, sysWaitMode, sysStopMode} = 5'h1F;
		{extClkTick, intClkTick, sysWaitMode, sysStopMode} = 4'h0;
		{awv, wv, bre, arv, rre, sawEvent} = 6'h00;
		ws = 4'hF;
		lastBresp = 2'h0;
		{awa, wd, ara} = '0;
		cyc(6);
		reset <= 1'b0;
		cyc(1);
		t_reset();
		t_config();
		t_frame();
		t_low();
		// Reset again in mid-run: defaults must return
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(1);
		t_reset();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
